// file: hw/branch_unit_pkg.sv
/*
 * shared constants and types for the branch, call and skip instruction unit
 * assumes: one 40 MHz core clock, synchronous active-high reset
 */
package branch_unit_pkg;

  typedef enum logic [4:0] {
    op_nop,
    op_compare_skip_equal_imm,
    op_compare_skip_equal_mem,
    op_increment_to_acc_skip_zero,
    op_increment_mem_skip_zero,
    op_decrement_to_acc_skip_zero,
    op_decrement_mem_skip_zero,
    op_skip_if_bit_clear,
    op_skip_if_bit_set,
    op_bank_zero_skip_if_bit_clear,
    op_bank_zero_skip_if_bit_set,
    op_jump,
    op_call,
    op_return,
    op_interrupt_return,
    op_save_context,
    op_restore_context
  } op_t;

  typedef enum {
    st_exec,
    st_write_back,
    st_skip,
    st_branch
  } state_t;

  localparam int          STACK_DEPTH     = 8;
  localparam int          STACK_PTR_W     = 3;

  // program_flag_register layout
  localparam int          FLAG_C_BIT      = 0;
  localparam int          FLAG_DC_BIT     = 1;
  localparam int          FLAG_Z_BIT      = 2;
  localparam int          FLAG_PD_BIT     = 6;
  localparam int          FLAG_TO_BIT     = 7;

  localparam logic [15:0] PC_RESET        = 16'h0000;
  localparam logic [7:0]  ACC_RESET       = 8'h00;
  localparam logic [1:0]  ROM_PAGE_RESET  = 2'h0;
  localparam logic [3:0]  BANK_ZERO       = 4'h0;

  // register map, byte addresses
  localparam logic [3:0]  REG_PAGE_OFS    = 4'h0;
  localparam logic [3:0]  REG_STATE_OFS   = 4'h4;
  localparam logic [3:0]  REG_CORE_OFS    = 4'h8;
  localparam int          STATE_PC_LSB    = 0;
  localparam int          STATE_FLAGS_LSB = 16;
  localparam int          STATE_ACC_LSB   = 24;
  localparam int          CORE_GIE_BIT    = 0;
  localparam int          CORE_SP_LSB     = 4;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

// file: hw/branch_unit.sv
/*
 * branch, call, return, skip and context save/restore execution for an
 * 8-bit core, with an axi4-lite slave for page select and state readback
 * assumes: the decoder presents one instruction with its operand value
 * (read combinationally at mem_raddr_o) and holds it until instr_ready_o
 */
`timescale 1ns/100ps

// Operation
// - compare immediate, set Z/C, skip if equal
// - compare memory, set Z/C, skip if equal
// - acc gets operand plus one, skip zero
// - memory gets operand plus one, skip zero
// - acc gets operand minus one, skip zero
// - memory gets operand minus one, skip zero
// - skip when tested memory bit is zero
// - skip when tested memory bit is one
// - bank-zero bit-clear test ignores bank select
// - bank-zero bit-set test ignores bank select
// - jump: page bits plus fourteen-bit field, two cycles
// - call pushes pc plus one then jumps, two cycles
// - returns pop pc; interrupt return sets enable
// - save copies acc and flags, not status
// - restore reloads acc and flags, keeps status
// - write-back cycle: zero sysreg, one RAM
// - skip cycle: one when condition true
module branch_unit
  import branch_unit_pkg::*;
(
  input  logic        clk_sys_i,
  input  logic        srst_i,
  input  logic        instr_valid_i,
  output logic        instr_ready_o,
  input  op_t         op_i,
  input  logic [7:0]  imm_i,
  input  logic [13:0] addr_i,
  input  logic [2:0]  bit_sel_i,
  input  logic [3:0]  bank_sel_i,
  input  logic        mem_is_sys_i,
  output logic [11:0] mem_raddr_o,
  input  logic [7:0]  mem_rdata_i,
  output logic        mem_we_o,
  output logic [11:0] mem_waddr_o,
  output logic [7:0]  mem_wdata_o,
  input  logic        timeout_status_bit_i,
  input  logic        power_down_status_bit_i,
  output logic [15:0] pc_o,
  output logic [7:0]  acc_o,
  output logic [7:0]  program_flag_register_o,
  output logic        gie_o,
  output logic        skip_cycle_o,
  input  logic [3:0]  s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  input  logic [3:0]  s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready
);

  function automatic logic [1:0] reg_sel(input logic [3:0] a);
    // 0 page, 1 state, 2 core, 3 unmapped
    if (a == REG_PAGE_OFS) return 2'd0;
    if (a == REG_STATE_OFS) return 2'd1;
    if (a == REG_CORE_OFS) return 2'd2;
    return 2'd3;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // execution state
  state_t                  state_q,     state_d;
  logic                    skip_pend_q, skip_pend_d;
  logic [15:0]             pc_q,        pc_d;
  logic [7:0]              acc_q,       acc_d;
  logic                    flag_c_q,    flag_c_d;
  logic                    flag_dc_q,   flag_dc_d;
  logic                    flag_z_q,    flag_z_d;
  logic                    gie_q,       gie_d;
  logic [7:0]              save_acc_q,  save_acc_d;
  logic [2:0]              save_flag_q, save_flag_d;
  logic [15:0]             stack_q [STACK_DEPTH];
  logic [15:0]             stack_d [STACK_DEPTH];
  logic [STACK_PTR_W-1:0]  sp_q,        sp_d;
  logic                    we_q,        we_d;
  logic [11:0]             waddr_q,     waddr_d;
  logic [7:0]              wdata_q,     wdata_d;
  logic [1:0]              page_q,      page_d;
  logic        bank0_op;
  logic        take;
  logic [8:0]  diff;
  logic [7:0]  inc_val;
  logic [7:0]  dec_val;
  logic        bit_val;
  logic        cond;
  logic        mem_write;
  assign bank0_op = (op_i == op_bank_zero_skip_if_bit_clear) ||
                    (op_i == op_bank_zero_skip_if_bit_set);
  assign mem_raddr_o = {bank0_op ? BANK_ZERO : bank_sel_i, addr_i[7:0]};
  assign take     = instr_valid_i && (state_q == st_exec);
  assign diff     = {1'b0, acc_q} - {1'b0, (op_i == op_compare_skip_equal_imm) ? imm_i : mem_rdata_i};
  assign inc_val  = mem_rdata_i + 8'h01;
  assign dec_val  = mem_rdata_i - 8'h01;
  assign bit_val  = mem_rdata_i[bit_sel_i];
  assign mem_write = (op_i == op_increment_mem_skip_zero) ||
                     (op_i == op_decrement_mem_skip_zero);

  always_comb begin
    cond = 1'b0;
    case (op_i)
      op_compare_skip_equal_imm, op_compare_skip_equal_mem: cond = (diff[7:0] == 8'h00);
      op_increment_to_acc_skip_zero, op_increment_mem_skip_zero: cond = (inc_val == 8'h00);
      op_decrement_to_acc_skip_zero, op_decrement_mem_skip_zero: cond = (dec_val == 8'h00);
      op_skip_if_bit_clear, op_bank_zero_skip_if_bit_clear: cond = !bit_val;
      op_skip_if_bit_set, op_bank_zero_skip_if_bit_set: cond = bit_val;
      default: cond = 1'b0;
    endcase
  end

  always_comb begin
    state_d     = state_q;
    skip_pend_d = skip_pend_q;
    pc_d        = pc_q;
    acc_d       = acc_q;
    flag_c_d    = flag_c_q;
    flag_dc_d   = flag_dc_q;
    flag_z_d    = flag_z_q;
    gie_d       = gie_q;
    save_acc_d  = save_acc_q;
    save_flag_d = save_flag_q;
    stack_d     = stack_q;
    sp_d        = sp_q;
    we_d        = 1'b0;
    waddr_d     = waddr_q;
    wdata_d     = wdata_q;
    case (state_q)
      st_exec: begin
        if (take) begin
          // nop and anything unlisted falls through with pc advance only; the bit tests can still skip on cond below
          pc_d = pc_q + 16'h0001;
          case (op_i)
            op_compare_skip_equal_imm, op_compare_skip_equal_mem: begin
              flag_z_d = (diff[7:0] == 8'h00);
              flag_c_d = !diff[8];
            end
            op_increment_to_acc_skip_zero: acc_d = inc_val;
            op_decrement_to_acc_skip_zero: acc_d = dec_val;
            op_increment_mem_skip_zero, op_decrement_mem_skip_zero: begin
              we_d    = 1'b1;
              waddr_d = mem_raddr_o;
              wdata_d = (op_i == op_increment_mem_skip_zero) ? inc_val : dec_val;
            end
            op_jump: begin
              pc_d    = {page_q, addr_i};
              state_d = st_branch;
            end
            op_call: begin
              stack_d[sp_q] = pc_q + 16'h0001;
              sp_d          = sp_q + 3'd1;
              pc_d          = {page_q, addr_i};
              state_d       = st_branch;
            end
            op_return, op_interrupt_return: begin
              sp_d    = sp_q - 3'd1;
              pc_d    = stack_q[sp_q - 3'd1];
              state_d = st_branch;
              if (op_i == op_interrupt_return) gie_d = 1'b1;
            end
            op_save_context: begin
              // status bits stay out of the buffer
              save_acc_d  = acc_q;
              save_flag_d = {flag_z_q, flag_dc_q, flag_c_q};
            end
            op_restore_context: begin
              acc_d     = save_acc_q;
              flag_z_d  = save_flag_q[2];
              flag_dc_d = save_flag_q[1];
              flag_c_d  = save_flag_q[0];
            end
            default: pc_d = pc_q + 16'h0001;
          endcase
          skip_pend_d = cond;
          if (mem_write && !mem_is_sys_i) begin
            state_d = st_write_back;
          end else if (cond) begin
            state_d = st_skip;
          end
        end
      end
      st_write_back: state_d = skip_pend_q ? st_skip : st_exec;
      st_skip: begin
        // fetched successor dropped: only the pc moves past it
        pc_d        = pc_q + 16'h0001;
        skip_pend_d = 1'b0;
        state_d     = st_exec;
      end
      st_branch: state_d = st_exec;
      default: state_d = st_exec;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_q     <= st_exec;
      skip_pend_q <= 1'b0;
      pc_q        <= PC_RESET;
      acc_q       <= ACC_RESET;
      flag_c_q    <= 1'b0;
      flag_dc_q   <= 1'b0;
      flag_z_q    <= 1'b0;
      gie_q       <= 1'b0;
      save_acc_q  <= ACC_RESET;
      save_flag_q <= 3'h0;
      for (int i = 0; i < STACK_DEPTH; i++) stack_q[i] <= PC_RESET;
      sp_q        <= '0;
      we_q        <= 1'b0;
      waddr_q     <= 12'h000;
      wdata_q     <= 8'h00;
    end else begin
      state_q     <= state_d;
      skip_pend_q <= skip_pend_d;
      pc_q        <= pc_d;
      acc_q       <= acc_d;
      flag_c_q    <= flag_c_d;
      flag_dc_q   <= flag_dc_d;
      flag_z_q    <= flag_z_d;
      gie_q       <= gie_d;
      save_acc_q  <= save_acc_d;
      save_flag_q <= save_flag_d;
      stack_q     <= stack_d;
      sp_q        <= sp_d;
      we_q        <= we_d;
      waddr_q     <= waddr_d;
      wdata_q     <= wdata_d;
    end
  end

  always_comb begin
    program_flag_register_o              = 8'h00;
    program_flag_register_o[FLAG_TO_BIT] = timeout_status_bit_i;
    program_flag_register_o[FLAG_PD_BIT] = power_down_status_bit_i;
    program_flag_register_o[FLAG_Z_BIT]  = flag_z_q;
    program_flag_register_o[FLAG_DC_BIT] = flag_dc_q;
    program_flag_register_o[FLAG_C_BIT]  = flag_c_q;
  end
  assign instr_ready_o = (state_q == st_exec);
  assign skip_cycle_o  = (state_q == st_skip);
  assign pc_o          = pc_q;
  assign acc_o         = acc_q;
  assign gie_o         = gie_q;
  assign mem_we_o      = we_q;
  assign mem_waddr_o   = waddr_q;
  assign mem_wdata_o   = wdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic        aw_got_q,  aw_got_d;
  logic        w_got_q,   w_got_d;
  logic [3:0]  awaddr_q,  awaddr_d;
  logic [31:0] wdat_q,    wdat_d;
  logic        wstrb0_q,  wstrb0_d;
  logic        bvalid_q,  bvalid_d;
  logic [1:0]  bresp_q,   bresp_d;
  logic        rvalid_q,  rvalid_d;
  logic [1:0]  rresp_q,   rresp_d;
  logic [31:0] rdata_q,   rdata_d;

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wdat_d   = wdat_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    page_d   = page_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_d  = 1'b1;
      wdat_d   = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (aw_got_q && w_got_q && !bvalid_q) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      case (reg_sel(awaddr_q))
        2'd0: if (wstrb0_q) page_d = wdat_q[1:0];
        2'd3: bresp_d = RESP_SLVERR;
        default: bresp_d = RESP_OKAY; // state words are read-only; writes are dropped
      endcase
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case (reg_sel(s_axi_araddr))
        2'd0: rdata_d[1:0] = page_q;
        2'd1: begin
          rdata_d[STATE_PC_LSB +: 16]   = pc_q;
          rdata_d[STATE_FLAGS_LSB +: 8] = program_flag_register_o;
          rdata_d[STATE_ACC_LSB +: 8]   = acc_q;
        end
        2'd2: begin
          rdata_d[CORE_GIE_BIT]                = gie_q;
          rdata_d[CORE_SP_LSB +: STACK_PTR_W]  = sp_q;
        end
        default: rresp_d = RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 4'h0;
      wdat_q   <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      page_q   <= ROM_PAGE_RESET;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      awaddr_q <= awaddr_d;
      wdat_q   <= wdat_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
      page_q   <= page_d;
    end
  end

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

endmodule

// file: dv/branch_unit_assertions.sv
/* port assertions for branch_unit
   assumes: bound into every branch_unit, one clock, sync active-high reset */
`timescale 1ns/100ps
module branch_unit_assertions
  import branch_unit_pkg::*;
(
  input logic        clk_sys_i,
  input logic        srst_i,
  input logic        instr_valid_i,
  input logic        instr_ready_o,
  input op_t         op_i,
  input logic [7:0]  imm_i,
  input logic [13:0] addr_i,
  input logic        mem_is_sys_i,
  input logic [11:0] mem_raddr_o,
  input logic [7:0]  mem_rdata_i,
  input logic        mem_we_o,
  input logic [7:0]  mem_wdata_o,
  input logic [15:0] pc_o,
  input logic [7:0]  acc_o,
  input logic        gie_o,
  input logic        skip_cycle_o
);
  logic tk;
  assign tk = instr_valid_i && instr_ready_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // branch ops: one busy cycle, then ready again
  sequence two_cyc_s;
    !instr_ready_o ##1 instr_ready_o;
  endsequence
  jump_target_a: assert property (tk && op_i == op_jump
    |=> pc_o[13:0] == $past(addr_i) ##0 two_cyc_s) else $error("jump target or cost wrong");
  call_cost_a: assert property (tk && op_i == op_call |=> two_cyc_s)
    else $error("call cost wrong");
  iret_gie_a: assert property (tk && op_i == op_interrupt_return |=> gie_o ##0 two_cyc_s)
    else $error("interrupt return wrong");
  cmp_skip_a: assert property (tk && op_i == op_compare_skip_equal_imm
    |=> skip_cycle_o == ($past(acc_o) == $past(imm_i))) else $error("compare skip wrong");
  inc_wb_a: assert property (tk && op_i == op_increment_mem_skip_zero
    |=> mem_we_o && mem_wdata_o == $past(mem_rdata_i) + 8'h01) else $error("increment write wrong");
  wb_cost_a: assert property (tk && op_i == op_decrement_mem_skip_zero && mem_rdata_i != 8'h01
    |=> instr_ready_o == $past(mem_is_sys_i)) else $error("write-back cost wrong");
  bank_zero_a: assert property (tk && op_i inside {op_bank_zero_skip_if_bit_clear,
    op_bank_zero_skip_if_bit_set} |-> mem_raddr_o[11:8] == 4'h0) else $error("bank not forced");
  inc_acc_a: assert property (tk && op_i == op_increment_to_acc_skip_zero
    |=> acc_o == $past(mem_rdata_i) + 8'h01) else $error("increment to acc wrong");
  nop_quiet_a: assert property (tk && op_i == op_nop
    |=> $stable(acc_o) && !mem_we_o && instr_ready_o) else $error("nop not quiet");
endmodule

bind branch_unit branch_unit_assertions branch_unit_assertions_inst (.*);

// file: dv/branch_unit_tb_top.sv
/* random and corner bench for branch_unit, with axi4-lite register checks
   assumes: package compiled first, checker attached by bind */
`timescale 1ns/100ps
module branch_unit_tb_top;
  import branch_unit_pkg::*;
  logic        clk_sys_i, srst_i, instr_valid_i, instr_ready_o, mem_is_sys_i, mem_we_o, gie_o;
  logic        skip_cycle_o, timeout_status_bit_i, power_down_status_bit_i;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  op_t         op_i;
  logic [7:0]  imm_i, mem_rdata_i, mem_wdata_o, acc_o, program_flag_register_o, e_acc, s_acc;
  logic [13:0] addr_i;
  logic [2:0]  bit_sel_i, e_sp;
  logic [3:0]  bank_sel_i, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [11:0] mem_raddr_o, mem_waddr_o;
  logic [15:0] pc_o, e_pc, stk[8];
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, page;
  logic        e_z, e_c, s_z, s_c, e_gie;
  int          err_total, compares, cyc;

  branch_unit branch_unit_inst (.*);

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // operand values biased toward skip boundaries
  function automatic logic [7:0] pick();
    case ($urandom_range(3))
      0: return 8'hff;
      1: return 8'h01;
      2: return e_acc;
      default: return 8'($urandom);
    endcase
  endfunction

  ////////////////////////////////////////
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] rs);
    logic ta, tw, aw, w;
    @(posedge clk_sys_i);
    q = '0;
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      {aw, w} = 2'b00;
      do begin
        @(negedge clk_sys_i);
        ta = !aw && s_axi_awready;
        tw = !w && s_axi_wready;
        @(posedge clk_sys_i);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        aw |= ta;
        w |= tw;
      end while (!(aw && w));
      do @(negedge clk_sys_i); while (!s_axi_bvalid);
      rs = s_axi_bresp;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clk_sys_i); while (!s_axi_arready);
      @(posedge clk_sys_i);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk_sys_i); while (!s_axi_rvalid);
      {rs, q} = {s_axi_rresp, s_axi_rdata};
    end
    @(posedge clk_sys_i);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask

  task automatic exec(input op_t o, input logic [7:0] im, input logic [13:0] ad, input logic [2:0] bs,
                      input logic [3:0] bk, input logic sy, input logic [7:0] rd);
    int n;
    int cost;
    logic sk, wb, br, sc;
    logic [7:0] r;
    @(posedge clk_sys_i);
    op_i <= o;
    imm_i <= im;
    addr_i <= ad;
    bit_sel_i <= bs;
    bank_sel_i <= bk;
    mem_is_sys_i <= sy;
    mem_rdata_i <= rd;
    timeout_status_bit_i <= 1'($urandom);
    power_down_status_bit_i <= 1'($urandom);
    instr_valid_i <= 1'b1;
    do @(negedge clk_sys_i); while (!instr_ready_o);
    br = o inside {op_bank_zero_skip_if_bit_clear, op_bank_zero_skip_if_bit_set};
    chk("raddr", {br ? 4'h0 : bk, ad[7:0]}, mem_raddr_o);
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    {sk, wb, br, sc} = 4'h0;
    r = rd;
    cost = 1;
    case (o)
      op_compare_skip_equal_imm, op_compare_skip_equal_mem: begin
        if (o == op_compare_skip_equal_imm) r = im;
        sk = e_acc == r;
        e_z = sk;
        e_c = e_acc >= r;
      end
      op_increment_to_acc_skip_zero, op_increment_mem_skip_zero,
      op_decrement_to_acc_skip_zero, op_decrement_mem_skip_zero: begin
        r = o inside {op_increment_to_acc_skip_zero, op_increment_mem_skip_zero} ? rd + 8'h01 : rd - 8'h01;
        sk = r == 8'h00;
        wb = o inside {op_increment_mem_skip_zero, op_decrement_mem_skip_zero};
        if (wb) cost += !sy;
        else e_acc = r;
      end
      op_skip_if_bit_clear, op_bank_zero_skip_if_bit_clear: sk = !rd[bs];
      op_skip_if_bit_set, op_bank_zero_skip_if_bit_set: sk = rd[bs];
      op_jump, op_call: begin
        if (o == op_call) stk[e_sp] = e_pc + 16'h0001;
        if (o == op_call) e_sp++;
        e_pc = {page, ad};
        {br, cost} = {1'b1, 32'd2};
      end
      op_return, op_interrupt_return: begin
        e_sp--;
        e_pc = stk[e_sp];
        e_gie |= o == op_interrupt_return;
        {br, cost} = {1'b1, 32'd2};
      end
      op_save_context: {s_acc, s_z, s_c} = {e_acc, e_z, e_c};
      op_restore_context: {e_acc, e_z, e_c} = {s_acc, s_z, s_c};
      default: ;
    endcase
    cost += sk;
    if (!br) e_pc += 16'h0001 + 16'(sk);
    @(negedge clk_sys_i);
    chk("mem we", wb, mem_we_o);
    if (wb) chk("mem wr", {bk, ad[7:0], r}, {mem_waddr_o, mem_wdata_o});
    n = 1;
    while (!instr_ready_o) begin
      sc |= skip_cycle_o;
      n++;
      @(negedge clk_sys_i);
    end
    chk("skip", sk, sc);
    chk("cost", cost, n);
    chk("pc", e_pc, pc_o);
    chk("acc", e_acc, acc_o);
    chk("flags", {timeout_status_bit_i, power_down_status_bit_i, e_z, 1'b0, e_c},
        {program_flag_register_o[7:6], program_flag_register_o[2:0]});
    chk("gie", e_gie, gie_o);
  endtask

  ////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic [1:0]  rs;
    op_t         o;
    srst_i = 1'b1;
    {instr_valid_i, imm_i, addr_i, bit_sel_i, bank_sel_i, mem_is_sys_i, mem_rdata_i} = '0;
    {timeout_status_bit_i, power_down_status_bit_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {e_pc, e_acc, e_sp, e_z, e_c, e_gie, page} = '0;
    op_i = op_nop;
    s_axi_wstrb = 4'hf;
    stk = '{default: 16'h0000};
    void'($urandom(32'h910523d4));
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    axi(0, REG_PAGE_OFS, 0, q, rs);
    chk("page reset", 0, q);
    axi(0, REG_CORE_OFS, 0, q, rs);
    chk("core reset", 0, q);
    axi(1, REG_STATE_OFS, 32'hffffffff, q, rs);
    chk("ro write", RESP_OKAY, rs);
    axi(0, 4'hc, 0, q, rs);
    chk("unmapped", {RESP_SLVERR, 32'h0}, {rs, q});
    // hand-picked corners before the random stream
    exec(op_save_context, 0, 0, 0, 0, 0, 0);
    exec(op_increment_mem_skip_zero, 0, 14'h0012, 0, 4'h3, 0, 8'hff);
    exec(op_decrement_mem_skip_zero, 0, 14'h0034, 0, 4'h1, 1, 8'h01);
    axi(1, REG_PAGE_OFS, 32'h3, q, rs);
    page = 2'h3;
    exec(op_call, 0, 14'h3abc, 0, 0, 0, 0);
    exec(op_interrupt_return, 0, 0, 0, 0, 0, 0);
    repeat (500) begin
      if ($urandom_range(15) == 0) begin
        page = 2'($urandom);
        axi(1, REG_PAGE_OFS, {30'h0, page}, q, rs);
        axi(0, REG_PAGE_OFS, 0, q, rs);
        chk("page", page, q);
      end
      o = op_t'($urandom_range(16));
      exec(o, pick(), 14'($urandom), 3'($urandom), 4'($urandom), 1'($urandom), pick());
    end
    axi(0, REG_STATE_OFS, 0, q, rs);
    chk("state", {e_acc, e_pc}, {q[31:24], q[15:0]});
    axi(0, REG_CORE_OFS, 0, q, rs);
    chk("core", {e_sp, e_gie}, {q[6:4], q[0]});
    close_out();
  end
endmodule
